//--- rtl/see_defines.vh
// Constants for the serial EEPROM command core.
// Assumes inclusion by bare name from the design file.
`ifndef SEE_DEFINES_VH
`define SEE_DEFINES_VH
`define SEE_OP_STATUS_WRITE_CMD_LOW   3'h1
`define SEE_OP_WRITE_LOW  3'h2
`define SEE_OP_READ_LOW   3'h3
`define SEE_OP_WRITE_DISABLE_CMD_LOW   3'h4
`define SEE_OP_STATUS_READ_CMD_LOW   3'h5
`define SEE_OP_WRITE_ENABLE_CMD_LOW   3'h6
`define SEE_ST_BUSY_BIT   0
`define SEE_ST_WEL_BIT    1
`define SEE_ST_BPL_BIT    2
`define SEE_ST_BPH_BIT    3
`define SEE_ST_UPPER      4'hF
`define SEE_TW_MS         5
`define SEE_CLK_MHZ       200
`define SEE_TW_CYCLES     (`SEE_TW_MS * `SEE_CLK_MHZ * 1000)
`define SEE_FIFO_DEPTH    8
`endif

//--- rtl/see_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module see_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,
  input  wire             rst_b,
  input  wire             clr,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_reg;
  reg [AW:0]      rp_reg;
  wire            full;
  wire            empty;
  assign empty     = (wp_reg == rp_reg);
  assign full      = (wp_reg[AW-1:0] == rp_reg[AW-1:0]) && (wp_reg[AW] != rp_reg[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_reg[AW-1:0]];
  always @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

//--- rtl/see_core.v
// Command core of a serial EEPROM on an SPI-style link, with array and protect bits.
// Assumes link pins come from outside; ref_clk oversamples them by far more than 2x.
`timescale 1ns/1ps
`include "see_defines.vh"
module see_core #(
  parameter ABITS     = 9,
  parameter TW_CYCLES = `SEE_TW_CYCLES
) (
  input  wire ref_clk,
  input  wire rst_b,
  input  wire sel_b,
  input  wire sclk,
  input  wire sdi,
  input  wire wp_b,
  output reg  sdo_out_reg,
  output reg  sdo_oe_b_reg,
  output reg  busy_flag_reg
);
  localparam ST_CMD  = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_RD   = 3'h2;
  localparam ST_WR   = 3'h3;
  localparam ST_STATUS_WRITE_CMD = 3'h4;
  localparam ST_STATUS_READ_CMD = 3'h5;
  localparam ST_WAIT = 3'h6;
  localparam CY_IDLE  = 2'h0;
  localparam CY_ERASE = 2'h1;
  localparam CY_PROG  = 2'h2;
  localparam DEPTH = 1 << ABITS;

  reg [7:0]       mem [0:DEPTH-1];
  reg [1:0]       sel_sync_reg;
  reg [1:0]       clk_sync_reg;
  reg [1:0]       sdi_sync_reg;
  reg [1:0]       wp_sync_reg;
  reg             sel_d_reg;
  reg             clk_d_reg;
  reg [2:0]       state_reg;
  reg [2:0]       bitcnt_reg;
  reg [7:0]       shin_reg;
  reg [7:0]       shout_reg;
  reg [ABITS-1:0] addr_reg;
  reg             a8_reg;
  reg             is_write_reg;
  reg             got_byte_reg;
  reg             mid_bit_reg;
  reg             wp_seen_reg;
  reg             write_enable_latch_reg;
  reg [1:0]       bp_reg;
  reg [7:0]       pend_bp_reg;
  reg             pend_sr_reg;
  reg [ABITS-1:0] page_base_reg;
  reg [1:0]       cyc_reg;
  reg [31:0]      cyc_cnt_reg;
  reg             cyc_sr_reg;
  wire            sel_b_s;
  wire            rise;
  wire            fall;
  wire            sel_rise;
  wire [7:0]      byte_in;
  wire [7:0]      status_byte;
  wire            f_valid;
  wire            f_ready;
  wire [ABITS+7:0] f_data;
  wire            f_out_valid;
  wire [ABITS+7:0] f_out_data;
  wire            drain;
  wire            wr_start;
  wire            fifo_clr;

  assign sel_b_s  = sel_sync_reg[1];
  assign rise     = !sel_b_s && clk_sync_reg[1] && !clk_d_reg;
  assign fall     = !sel_b_s && !clk_sync_reg[1] && clk_d_reg;
  assign sel_rise = sel_b_s && !sel_d_reg;
  assign byte_in  = {shin_reg[6:0], sdi_sync_reg[1]};
  // Status byte with fixed ones on top and live latch/busy.
  assign status_byte = {`SEE_ST_UPPER, bp_reg, write_enable_latch_reg, busy_flag_reg};

  // Protect decode: 01 quarter, 10 half, 11 all.
  function guarded;
    input [1:0]       bp;
    input [ABITS-1:0] a;
    begin
      case (bp)
        2'h1:    guarded = &a[ABITS-1:ABITS-2];
        2'h2:    guarded = a[ABITS-1];
        2'h3:    guarded = 1'b1;
        default: guarded = 1'b0;
      endcase
    end
  endfunction

  // Next address within the 16-byte page.
  function [ABITS-1:0] page_inc;
    input [ABITS-1:0] a;
    begin
      page_inc = {a[ABITS-1:4], a[3:0] + 4'h1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      wp_sync_reg  <= 2'h3;
      sel_d_reg    <= 1'b1;
      clk_d_reg    <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], sel_b};
      clk_sync_reg <= {clk_sync_reg[0], sclk};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi};
      wp_sync_reg  <= {wp_sync_reg[0], wp_b};
      sel_d_reg    <= sel_sync_reg[1];
      clk_d_reg    <= clk_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write data buffer between the link and the array.
  // Bytes of a write refused for a running cycle never reach the buffer.
  assign f_valid  = rise && (state_reg == ST_WR) && (bitcnt_reg == 3'h7) && (cyc_reg == CY_IDLE);
  assign wr_start = sel_rise && !mid_bit_reg && (cyc_reg == CY_IDLE) && wp_seen_reg
                    && write_enable_latch_reg && is_write_reg && got_byte_reg;
  // Refused writes drop their bytes; a running cycle keeps its own.
  assign fifo_clr = sel_rise && (cyc_reg == CY_IDLE) && !wr_start;
  assign f_data  = {addr_reg, byte_in};
  assign drain   = (cyc_reg == CY_PROG) && (cyc_cnt_reg == 32'h0);

  see_fifo #(.WIDTH(ABITS + 8), .DEPTH(`SEE_FIFO_DEPTH), .AW(3)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .clr       (fifo_clr),
    .in_data   (f_data),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (drain)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer and status.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg              <= ST_CMD;
      bitcnt_reg             <= 3'h0;
      shin_reg               <= 8'h00;
      shout_reg              <= 8'h00;
      addr_reg               <= {ABITS{1'b0}};
      a8_reg                 <= 1'b0;
      is_write_reg           <= 1'b0;
      got_byte_reg           <= 1'b0;
      mid_bit_reg            <= 1'b0;
      wp_seen_reg            <= 1'b1;
      write_enable_latch_reg <= 1'b0;
      bp_reg                 <= 2'h0;
      pend_bp_reg            <= 8'h00;
      pend_sr_reg            <= 1'b0;
      page_base_reg          <= {ABITS{1'b0}};
      cyc_reg                <= CY_IDLE;
      cyc_cnt_reg            <= 32'h0;
      cyc_sr_reg             <= 1'b0;
      busy_flag_reg          <= 1'b0;
      sdo_out_reg            <= 1'b0;
      sdo_oe_b_reg           <= 1'b1;
    end else begin
      busy_flag_reg <= (cyc_reg != CY_IDLE);
      if (!wp_sync_reg[1]) begin
        write_enable_latch_reg <= 1'b0;
      end
      if (sel_b_s) begin
        // Deselect ends every command and floats the output.
        state_reg    <= ST_CMD;
        bitcnt_reg   <= 3'h0;
        sdo_oe_b_reg <= 1'b1;
        mid_bit_reg  <= 1'b0;
        wp_seen_reg  <= 1'b1;
        got_byte_reg <= 1'b0;
        is_write_reg <= 1'b0;
        pend_sr_reg  <= 1'b0;
        if (sel_rise && !mid_bit_reg && cyc_reg == CY_IDLE && wp_seen_reg
            && write_enable_latch_reg) begin
          if (pend_sr_reg && !is_write_reg) begin
            // Start a status write cycle.
            cyc_reg     <= CY_ERASE;
            cyc_sr_reg  <= 1'b1;
            cyc_cnt_reg <= TW_CYCLES / 2;
          end else if (is_write_reg && got_byte_reg) begin
            cyc_reg     <= CY_ERASE;
            cyc_sr_reg  <= 1'b0;
            cyc_cnt_reg <= TW_CYCLES / 2;
          end
        end
      end else begin
        if (!wp_sync_reg[1]) begin
          wp_seen_reg <= 1'b0;
        end
        if (rise) begin
          shin_reg    <= byte_in;
          bitcnt_reg  <= bitcnt_reg + 3'h1;
          mid_bit_reg <= (bitcnt_reg != 3'h7);
        end
        if (fall && (state_reg == ST_RD || state_reg == ST_STATUS_READ_CMD)) begin
          sdo_oe_b_reg <= 1'b0;
          sdo_out_reg  <= shout_reg[7];
          shout_reg    <= {shout_reg[6:0], 1'b0};
        end
        if (rise && bitcnt_reg == 3'h7) begin
          case (state_reg)
            ST_CMD: begin
              a8_reg <= byte_in[3];
              if (byte_in[7:4] != 4'h0) begin
                state_reg <= ST_WAIT;
              end else begin
                case (byte_in[2:0])
                  `SEE_OP_WRITE_ENABLE_CMD_LOW: begin
                    write_enable_latch_reg <= wp_sync_reg[1];
                    state_reg <= ST_WAIT;
                  end
                  `SEE_OP_WRITE_DISABLE_CMD_LOW: begin
                    write_enable_latch_reg <= 1'b0;
                    state_reg <= ST_WAIT;
                  end
                  `SEE_OP_STATUS_READ_CMD_LOW: begin
                    shout_reg <= status_byte;
                    state_reg <= ST_STATUS_READ_CMD;
                  end
                  `SEE_OP_STATUS_WRITE_CMD_LOW: state_reg <= ST_STATUS_WRITE_CMD;
                  `SEE_OP_READ_LOW: state_reg <= (cyc_reg != CY_IDLE) ? ST_WAIT
                                                 : ST_ADDR;
                  `SEE_OP_WRITE_LOW: begin
                    is_write_reg <= 1'b1;
                    state_reg    <= ST_ADDR;
                  end
                  default: state_reg <= ST_WAIT;
                endcase
              end
            end
            ST_ADDR: begin
              addr_reg      <= ABITS > 8 ? {a8_reg, byte_in} : byte_in;
              page_base_reg <= ABITS > 8 ? {a8_reg, byte_in} : byte_in;
              if (is_write_reg) begin
                state_reg <= guarded(bp_reg, ABITS > 8 ? {a8_reg, byte_in} : byte_in)
                             ? ST_WAIT : ST_WR;
              end else begin
                shout_reg <= mem[ABITS > 8 ? {a8_reg, byte_in} : byte_in];
                addr_reg  <= (ABITS > 8 ? {a8_reg, byte_in} : byte_in) + 1'b1;
                state_reg <= ST_RD;
              end
            end
            ST_RD: begin
              shout_reg <= mem[addr_reg];
              addr_reg  <= addr_reg + 1'b1;
            end
            ST_STATUS_READ_CMD: shout_reg <= status_byte;
            ST_WR: begin
              got_byte_reg <= 1'b1;
              addr_reg     <= page_inc(addr_reg);
            end
            ST_STATUS_WRITE_CMD: begin
              pend_bp_reg <= byte_in;
              pend_sr_reg <= 1'b1;
              state_reg   <= ST_WAIT;
            end
            default: state_reg <= ST_WAIT;
          endcase
        end
      end
      // Self-timed cycle: erase phase then program phase.
      if (cyc_reg != CY_IDLE) begin
        if (cyc_cnt_reg != 32'h0) begin
          cyc_cnt_reg <= cyc_cnt_reg - 32'h1;
        end else if (cyc_reg == CY_ERASE) begin
          cyc_reg     <= CY_PROG;
          cyc_cnt_reg <= TW_CYCLES - TW_CYCLES / 2;
        end else if (!f_out_valid) begin
          cyc_reg                <= CY_IDLE;
          write_enable_latch_reg <= 1'b0;
          if (cyc_sr_reg) begin
            bp_reg <= {pend_bp_reg[`SEE_ST_BPH_BIT], pend_bp_reg[`SEE_ST_BPL_BIT]};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array storage; buffered bytes are written when the program phase count runs out.
  always @(posedge ref_clk) begin
    if (drain && f_out_valid) begin
      mem[f_out_data[ABITS+7:8]] <= f_out_data[7:0];
    end
  end
endmodule

//--- dv/see_core_asserts.sv
// Checker for the serial EEPROM command core, watching only its top-level ports.
// Assumes ref_clk oversamples the link pins and rst_b is asynchronous, active low.
`timescale 1ns/1ps
module see_core_asserts #(
  parameter TW_CYCLES = 200
) (
  input wire ref_clk,
  input wire rst_b,
  input wire sel_b,
  input wire sclk,
  input wire sdi,
  input wire wp_b,
  input wire sdo_out_reg,
  input wire sdo_oe_b_reg,
  input wire busy_flag_reg
);
  reg        sclk_q;
  reg [4:0]  rise_cnt;
  reg [19:0] busy_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // Counts link clock rises in a frame and cycles of one busy period.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q   <= 1'b0;
      rise_cnt <= 5'h00;
      busy_cnt <= 20'h00000;
    end else begin
      sclk_q   <= sclk;
      rise_cnt <= sel_b ? 5'h00 : rise_cnt + {4'h0, sclk & ~sclk_q};
      busy_cnt <= busy_flag_reg ? busy_cnt + 20'h00001 : 20'h00000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_float_desel: assert property (sel_b [*6] |-> sdo_oe_b_reg)
    else $error("output enabled while deselected");
  a_drive_after_cmd: assert property ($fell(sdo_oe_b_reg) |-> !sel_b && (rise_cnt == 5'h08 || rise_cnt == 5'h10))
    else $error("output enabled at a wrong bit count");
  a_busy_after_desel: assert property ($rose(busy_flag_reg) |-> $past(sel_b, 2) && sdo_oe_b_reg)
    else $error("busy rose without a deselect");
  a_busy_min_hold: assert property ($rose(busy_flag_reg) |=> busy_flag_reg [*8])
    else $error("busy dropped early");
  a_busy_length: assert property ($fell(busy_flag_reg) |-> busy_cnt >= TW_CYCLES && busy_cnt <= TW_CYCLES + 64)
    else $error("busy period has a wrong length");
  a_busy_no_restart: assert property ($fell(busy_flag_reg) |=> !busy_flag_reg [*4])
    else $error("busy restarted without a command");
  a_sdo_low_clk: assert property (!sel_b && !sdo_oe_b_reg && $changed(sdo_out_reg) |-> !sclk)
    else $error("output changed while link clock high");
  a_sdo_hold_high: assert property ((!sel_b && sclk) [*3] |-> $stable(sdo_out_reg))
    else $error("output not held while link clock high");
  c_drive: cover property ($fell(sdo_oe_b_reg));
  c_busy_end: cover property ($fell(busy_flag_reg));
  c_array_read: cover property (rise_cnt == 5'h10 && !sdo_oe_b_reg);
endmodule
bind see_core see_core_asserts #(.TW_CYCLES(TW_CYCLES)) see_core_asserts_inst (
  .ref_clk(ref_clk), .rst_b(rst_b), .sel_b(sel_b), .sclk(sclk), .sdi(sdi), .wp_b(wp_b),
  .sdo_out_reg(sdo_out_reg), .sdo_oe_b_reg(sdo_oe_b_reg), .busy_flag_reg(busy_flag_reg));

//--- dv/see_spi_host.sv
// Host model on the link: select, link clock at 64 ns and data in, mode 0.
// Assumes the data-out line has a pull-up when the device does not drive it.
`timescale 1ns/1ps
module see_spi_host (
  output reg  sel_b,
  output reg  sclk,
  output reg  sdi,
  input  wire sdo_out,
  input  wire sdo_oe_b
);
  wire sdo_line = sdo_oe_b ? 1'b1 : sdo_out;
  initial begin
    sel_b = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shifts one byte out MSB first and samples the reply on each rise.
  task shift(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sdi = tx[i];
        #32 sclk = 1'b1;
        rx[i] = sdo_line;
        #32 sclk = 1'b0;
      end
    end
  endtask
  task open_frame;
    begin
      sel_b = 1'b0;
      #40;
    end
  endtask
  // Raises select between the last rise and the next one.
  task close_frame;
    begin
      #16 sel_b = 1'b1;
      sdi = ~sdi;
      #100;
    end
  endtask
endmodule

//--- dv/see_core_tb.sv
// Testbench for the serial EEPROM command core: status, array and protect scenarios.
// Assumes the host model drives the link pins; self-timed cycle shortened to 2000.
`timescale 1ns/1ps
module see_core_tb;
  reg        ref_clk;
  reg        rst_b;
  reg        wp_b;
  wire       sel_b;
  wire       sclk;
  wire       sdi;
  wire       sdo_out_reg;
  wire       sdo_oe_b_reg;
  wire       busy_flag_reg;
  reg  [7:0] txq [0:7];
  reg  [7:0] rxq [0:7];
  reg  [7:0] em  [0:2];
  reg  [8:0] pa  [0:2];
  integer    failures;
  integer    samples_checked;
  integer    c;
  integer    j;
  see_core #(.ABITS(9), .TW_CYCLES(2000)) see_core_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .sel_b(sel_b), .sclk(sclk), .sdi(sdi), .wp_b(wp_b),
    .sdo_out_reg(sdo_out_reg), .sdo_oe_b_reg(sdo_oe_b_reg), .busy_flag_reg(busy_flag_reg));
  see_spi_host see_spi_host_inst (
    .sel_b(sel_b), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out_reg), .sdo_oe_b(sdo_oe_b_reg));
  always #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task frame(input integer n);
    integer k;
    begin
      see_spi_host_inst.open_frame;
      for (k = 0; k < n; k = k + 1) see_spi_host_inst.shift(txq[k], rxq[k]);
      see_spi_host_inst.close_frame;
    end
  endtask
  task op1(input [7:0] op);
    begin
      txq[0] = op;
      frame(1);
    end
  endtask
  // Reads the status byte twice in one frame; both copies must match.
  task rd_status(input [7:0] exp);
    begin
      txq[0] = 8'h05;
      frame(3);
      chk(rxq[1], exp);
      chk(rxq[2], exp);
    end
  endtask
  task wr(input [8:0] a, input integer n);
    begin
      txq[0] = {4'h0, a[8], 3'h2};
      txq[1] = a[7:0];
      frame(n + 2);
    end
  endtask
  task rd(input [8:0] a, input integer n);
    begin
      txq[0] = {4'h0, a[8], 3'h3};
      txq[1] = a[7:0];
      frame(n + 2);
    end
  endtask
  task wait_idle;
    integer t;
    begin
      t = 0;
      while (busy_flag_reg !== 1'b0 && t < 3000) begin
        @(posedge ref_clk);
        t = t + 1;
      end
      if (t >= 3000) begin
        failures = failures + 1;
        report_and_stop;
      end
    end
  endtask
  task status_write_cmd(input [1:0] bp);
    begin
      op1(8'h06);
      txq[0] = 8'h01;
      txq[1] = {4'hF, bp, 2'h3};
      frame(2);
      wait_idle;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    wp_b = 1'b1;
    failures = 0;
    samples_checked = 0;
    pa[0] = 9'h000;
    pa[1] = 9'h100;
    pa[2] = 9'h180;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_status(8'hF0);
    op1(8'h0E);
    rd_status(8'hF2);
    txq[1] = 8'h06;
    txq[0] = 8'h0C;
    frame(2);
    rd_status(8'hF0);
    op1(8'h06);
    txq[2] = 8'h5A;
    wr(9'h000, 1);
    rd(9'h000, 1);
    chk(rxq[2], 8'hFF);
    rd_status(8'hF3);
    wait_idle;
    rd_status(8'hF0);
    txq[2] = 8'h77;
    wr(9'h000, 1);
    rd(9'h000, 1);
    chk(rxq[2], 8'h5A);
    op1(8'h06);
    txq[2] = 8'h11;
    txq[3] = 8'h22;
    txq[4] = 8'h33;
    txq[5] = 8'h44;
    wr(9'h1FE, 4);
    wait_idle;
    rd(9'h1FE, 3);
    chk(rxq[2], 8'h11);
    chk(rxq[4], 8'h5A);
    rd(9'h1F0, 2);
    chk(rxq[2], 8'h33);
    chk(rxq[3], 8'h44);
    for (c = 0; c < 4; c = c + 1) begin
      status_write_cmd(c[1:0]);
      for (j = 0; j < 3; j = j + 1) begin
        op1(8'h06);
        txq[2] = {c[3:0], j[3:0]};
        wr(pa[j], 1);
        wait_idle;
        if (c + j <= 2) em[j] = txq[2];
        rd(pa[j], 1);
        chk(rxq[2], em[j]);
      end
    end
    rd_status(8'hFE);
    @(posedge ref_clk) wp_b <= 1'b0;
    rd_status(8'hFC);
    status_write_cmd(2'h0);
    rd_status(8'hFC);
    report_and_stop;
  end
endmodule
